//--- logic/ldsr_consts.vh
// constants shared by the local dimming serial receiver files
`ifndef LDSR_CONSTS_VH
`define LDSR_CONSTS_VH

// register byte offsets on the plain register port
`define LDSR_REG_CTRL 8'h00
`define LDSR_REG_STATUS 8'h04
`define LDSR_REG_ERRCNT 8'h08
`define LDSR_REG_FRMCNT 8'h0C
`define LDSR_REG_GRAY0 8'h10
`define LDSR_REG_GRAY1 8'h14
`define LDSR_REG_GRAY2 8'h18
`define LDSR_REG_GRAY3 8'h1C

// control register fields
`define LDSR_CTRL_FMT10_BIT 0
`define LDSR_CTRL_HOLD_BIT 1
`define LDSR_CTRL_RESET 2'h0

// status register fields
`define LDSR_STAT_DIM_BIT 0
`define LDSR_STAT_SCAN_BIT 1
`define LDSR_STAT_REV_BIT 2
`define LDSR_STAT_OVF_BIT 3
`define LDSR_STAT_EMPTY_BIT 4

// command word fields
`define LDSR_CMD_DIM_BIT 0
`define LDSR_CMD_SCAN_BIT 1
`define LDSR_CMD_REV_BIT 7

// frame layout
`define LDSR_IND8 10'h0AA
`define LDSR_IND10 10'h280
`define LDSR_BITS8 4'h8
`define LDSR_BITS10 4'hA
`define LDSR_FRAME_WORDS 3'h7
`define LDSR_IDX_CMD 3'h1
`define LDSR_IDX_SUM 3'h6

// serial clock limits in kHz, and the system clock in kHz
`define LDSR_SCLK_MIN_KHZ 100
`define LDSR_SCLK_MAX_KHZ 500
`define LDSR_SYSCLK_KHZ 100000
// fastest link clock spans this many system clocks per half period
`define LDSR_SCLK_HALF_CYC (`LDSR_SYSCLK_KHZ / (2 * `LDSR_SCLK_MAX_KHZ))

`endif

//--- logic/ldsr_fifo.v
// word FIFO between the serial shifter and the frame assembler
`timescale 1ns/10ps
`default_nettype none

module ldsr_fifo #(
	parameter WIDTH = 11,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	input wire in_valid_i,
	output wire in_ready_o,
	input wire [WIDTH-1:0] in_data_i,
	output wire out_valid_o,
	input wire out_ready_i,
	output wire [WIDTH-1:0] out_data_o,
	output wire empty_o
);

	reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_reg;
	reg [AW-1:0] rd_ptr_reg;
	reg [AW:0] count_reg;
	wire do_wr;
	wire do_rd;

	// full and empty come from the occupancy count, so DEPTH need not be a power of two
	assign in_ready_o = (count_reg != DEPTH[AW:0]);
	assign out_valid_o = (count_reg != {(AW+1){1'b0}});
	assign empty_o = ~out_valid_o;
	assign out_data_o = mem_reg[rd_ptr_reg];
	assign do_wr = in_valid_i & in_ready_o & ce_i;
	assign do_rd = out_valid_o & out_ready_i & ce_i;

	// storage write, no reset needed for the data itself
	always @(posedge clk_i) begin
		if (do_wr) begin
			mem_reg[wr_ptr_reg] <= in_data_i;
		end
	end

	// pointers wrap at DEPTH
	always @(posedge clk_i) begin
		if (rst_i) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
		end else begin
			if (do_wr) begin
				wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
			end
			if (do_rd) begin
				rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
			end
			if (do_wr & ~do_rd) begin
				count_reg <= count_reg + 1'b1;
			end else if (do_rd & ~do_wr) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end

endmodule

`default_nettype wire

//--- logic/ldsr_top.v
// local dimming serial receiver: link sampler, word FIFO, frame checker, registers
//
// What this block does
// - 8-bit format: seven 8-bit words, indicator, command, four grays, checksum.
// - 10-bit format: same order, 10-bit words, indicator 1010_0000_00.
// - first word is indicator 1010_1010 in the 8-bit format; it starts a new dimming sequence.
// - command bit 0 switches local dimming on or off.
// - command bit 1 switches backlight scanning on or off.
// - command bit 7 set selects reverse scan direction, clear keeps normal.
// - four data words are per-block gray levels, 8 or 10 bits wide.
// - one dimming sequence per frame-sync period.
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "ldsr_consts.vh"

module ldsr_top #(
	parameter GRAY_W = 10,
	parameter FIFO_DEPTH = 16,
	parameter FIFO_AW = 4
) (
	input wire SYS_CLK_I,
	input wire RESET_I,
	input wire CE_I,
	input wire FRAME_SYNC_PULSE_I,
	input wire DIMMING_SERIAL_CLK_I,
	input wire DIMMING_SERIAL_INPUT_I,
	input wire [7:0] ADDR_I,
	input wire [31:0] WR_DATA_I,
	input wire WR_STB_I,
	input wire RD_STB_I,
	output reg [31:0] RD_DATA_O,
	output reg LOCAL_DIM_EN_O,
	output reg SCAN_EN_O,
	output reg REVERSE_O,
	output wire [GRAY_W-1:0] GRAY0_O,
	output wire [GRAY_W-1:0] GRAY1_O,
	output wire [GRAY_W-1:0] GRAY2_O,
	output wire [GRAY_W-1:0] GRAY3_O,
	output reg FRAME_OK_O,
	output reg CHECKSUM_ERR_O
);

	localparam FW = GRAY_W + 1;
	localparam ASM_WAIT = 1'b0;
	localparam ASM_BODY = 1'b1;

	// pin synchronisers and edge history
	reg sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
	reg sd_s1_reg, sd_s2_reg;
	reg fs_s1_reg, fs_s2_reg, fs_s3_reg;
	// shifter state
	reg [GRAY_W-1:0] shift_reg;
	reg [3:0] bit_cnt_reg;
	reg [2:0] word_cnt_reg;
	reg push_valid_reg;
	reg [FW-1:0] push_data_reg;
	// registers
	reg [1:0] ctrl_reg;
	reg ovf_reg;
	reg [7:0] err_cnt_reg;
	reg [7:0] frm_cnt_reg;
	// assembler state
	reg asm_state_reg;
	reg [2:0] asm_idx_reg;
	reg [GRAY_W-1:0] asm_xor_reg;
	reg [GRAY_W-1:0] asm_cmd_reg;
	reg [GRAY_W-1:0] gray_tmp_reg [0:3];
	reg [GRAY_W-1:0] gray_reg [0:3];
	reg apply_reg;

	wire sclk_rise;
	wire fs_rise;
	wire fmt10;
	wire [3:0] word_bits;
	wire [GRAY_W-1:0] shift_next;
	wire [GRAY_W-1:0] word_mask;
	wire [GRAY_W-1:0] indicator;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire fifo_empty;
	wire [FW-1:0] fifo_out_data;
	wire pop;
	wire pop_first;
	wire [GRAY_W-1:0] pop_word;
	wire [GRAY_W-1:0] xor_next;
	wire ovf_clr;

	assign fmt10 = ctrl_reg[`LDSR_CTRL_FMT10_BIT];
	assign word_bits = fmt10 ? `LDSR_BITS10 : `LDSR_BITS8;
	assign word_mask = fmt10 ? {GRAY_W{1'b1}} : {{(GRAY_W-8){1'b0}}, 8'hFF};
	assign indicator = fmt10 ? `LDSR_IND10 : `LDSR_IND8;
	// only stage two and three feed the edge detectors, stage one is left alone
	assign sclk_rise = sclk_s2_reg & ~sclk_s3_reg;
	assign fs_rise = fs_s2_reg & ~fs_s3_reg;
	assign shift_next = {shift_reg[GRAY_W-2:0], sd_s2_reg};
	// holding the drain lets software freeze settings; words then pile up in the FIFO
	assign pop = fifo_out_valid & ~ctrl_reg[`LDSR_CTRL_HOLD_BIT] & CE_I;
	assign pop_first = fifo_out_data[FW-1];
	assign pop_word = fifo_out_data[GRAY_W-1:0];
	assign xor_next = asm_xor_reg ^ pop_word;
	assign ovf_clr = WR_STB_I & (ADDR_I == `LDSR_REG_STATUS) & WR_DATA_I[`LDSR_STAT_OVF_BIT];

	// two flip-flops on every pin, a third only for edge history
	always @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			sclk_s1_reg <= 1'b0;
			sclk_s2_reg <= 1'b0;
			sclk_s3_reg <= 1'b0;
			sd_s1_reg <= 1'b0;
			sd_s2_reg <= 1'b0;
			fs_s1_reg <= 1'b0;
			fs_s2_reg <= 1'b0;
			fs_s3_reg <= 1'b0;
		end else if (CE_I) begin
			sclk_s1_reg <= DIMMING_SERIAL_CLK_I;
			sclk_s2_reg <= sclk_s1_reg;
			sclk_s3_reg <= sclk_s2_reg;
			sd_s1_reg <= DIMMING_SERIAL_INPUT_I;
			sd_s2_reg <= sd_s1_reg;
			fs_s1_reg <= FRAME_SYNC_PULSE_I;
			fs_s2_reg <= fs_s1_reg;
			fs_s3_reg <= fs_s2_reg;
		end
	end

	// serial shifter; a sync edge realigns the word count to a fresh sequence
	always @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			shift_reg <= {GRAY_W{1'b0}};
			bit_cnt_reg <= 4'h0;
			word_cnt_reg <= `LDSR_FRAME_WORDS;
			push_valid_reg <= 1'b0;
			push_data_reg <= {FW{1'b0}};
		end else if (CE_I) begin
			push_valid_reg <= 1'b0;
			if (fs_rise) begin
				shift_reg <= {GRAY_W{1'b0}};
				bit_cnt_reg <= 4'h0;
				word_cnt_reg <= 3'h0;
			end else if (sclk_rise && (word_cnt_reg != `LDSR_FRAME_WORDS)) begin
				// bits after the seventh word wait for the next sync edge
				shift_reg <= shift_next;
				if (bit_cnt_reg == word_bits - 4'h1) begin
					bit_cnt_reg <= 4'h0;
					word_cnt_reg <= word_cnt_reg + 3'h1;
					push_valid_reg <= 1'b1;
					push_data_reg <= {(word_cnt_reg == 3'h0), shift_next & word_mask};
				end else begin
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
				end
			end
		end
	end

	// the link cannot be stalled, so a word meeting a full FIFO is dropped and flagged
	ldsr_fifo #(
		.WIDTH(FW),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.clk_i(SYS_CLK_I),
		.rst_i(RESET_I),
		.ce_i(CE_I),
		.in_valid_i(push_valid_reg),
		.in_ready_o(fifo_in_ready),
		.in_data_i(push_data_reg),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(~ctrl_reg[`LDSR_CTRL_HOLD_BIT]),
		.out_data_o(fifo_out_data),
		.empty_o(fifo_empty)
	);

	// frame assembler: waits for an indicator, gathers six more words, checks the sum
	always @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			asm_state_reg <= ASM_WAIT;
			asm_idx_reg <= 3'h0;
			asm_xor_reg <= {GRAY_W{1'b0}};
			asm_cmd_reg <= {GRAY_W{1'b0}};
			apply_reg <= 1'b0;
			CHECKSUM_ERR_O <= 1'b0;
		end else if (CE_I) begin
			apply_reg <= 1'b0;
			CHECKSUM_ERR_O <= 1'b0;
			if (pop) begin
				if (pop_first) begin
					// a new first word always ends the current frame, even mid-frame; only an indicator starts another
					if (pop_word == indicator) begin
						asm_state_reg <= ASM_BODY;
						asm_idx_reg <= `LDSR_IDX_CMD;
						asm_xor_reg <= pop_word;
					end else begin
						asm_state_reg <= ASM_WAIT;
					end
				end else begin
					case (asm_state_reg)
						ASM_WAIT: begin
							asm_idx_reg <= 3'h0;
						end
						ASM_BODY: begin
							asm_xor_reg <= xor_next;
							asm_idx_reg <= asm_idx_reg + 3'h1;
							if (asm_idx_reg == `LDSR_IDX_CMD) begin
								asm_cmd_reg <= pop_word;
							end
							if (asm_idx_reg == `LDSR_IDX_SUM) begin
								asm_state_reg <= ASM_WAIT;
								// sum equals xor of the first six words when all seven xor to zero
								if (xor_next == {GRAY_W{1'b0}}) begin
									apply_reg <= 1'b1;
								end else begin
									CHECKSUM_ERR_O <= 1'b1;
								end
							end
						end
						default: begin
							asm_state_reg <= ASM_WAIT;
						end
					endcase
				end
			end
		end
	end

	// per-block gray capture and apply; a bad frame never reaches the applied set
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_block
			always @(posedge SYS_CLK_I) begin
				if (RESET_I) begin
					gray_tmp_reg[gi] <= {GRAY_W{1'b0}};
					gray_reg[gi] <= {GRAY_W{1'b0}};
				end else if (CE_I) begin
					if (pop && !pop_first && (asm_state_reg == ASM_BODY) &&
					    (asm_idx_reg == gi + 2)) begin
						gray_tmp_reg[gi] <= pop_word;
					end
					if (apply_reg) begin
						gray_reg[gi] <= gray_tmp_reg[gi];
					end
				end
			end
		end
	endgenerate

	assign GRAY0_O = gray_reg[0];
	assign GRAY1_O = gray_reg[1];
	assign GRAY2_O = gray_reg[2];
	assign GRAY3_O = gray_reg[3];

	// command outputs change only when a whole frame has passed its check
	always @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			LOCAL_DIM_EN_O <= 1'b0;
			SCAN_EN_O <= 1'b0;
			REVERSE_O <= 1'b0;
			FRAME_OK_O <= 1'b0;
		end else if (CE_I) begin
			FRAME_OK_O <= apply_reg;
			if (apply_reg) begin
				LOCAL_DIM_EN_O <= asm_cmd_reg[`LDSR_CMD_DIM_BIT];
				SCAN_EN_O <= asm_cmd_reg[`LDSR_CMD_SCAN_BIT];
				REVERSE_O <= asm_cmd_reg[`LDSR_CMD_REV_BIT];
			end
		end
	end

	// register writes and counters; overflow set beats a clear in the same cycle
	always @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			ctrl_reg <= `LDSR_CTRL_RESET;
			ovf_reg <= 1'b0;
			err_cnt_reg <= 8'h00;
			frm_cnt_reg <= 8'h00;
		end else if (CE_I) begin
			if (WR_STB_I && (ADDR_I == `LDSR_REG_CTRL)) begin
				ctrl_reg <= WR_DATA_I[1:0];
			end
			if (push_valid_reg && !fifo_in_ready) begin
				ovf_reg <= 1'b1;
			end else if (ovf_clr) begin
				ovf_reg <= 1'b0;
			end
			if (WR_STB_I && (ADDR_I == `LDSR_REG_ERRCNT)) begin
				err_cnt_reg <= 8'h00;
			end else if (CHECKSUM_ERR_O && (err_cnt_reg != 8'hFF)) begin
				err_cnt_reg <= err_cnt_reg + 8'h01;
			end
			if (WR_STB_I && (ADDR_I == `LDSR_REG_FRMCNT)) begin
				frm_cnt_reg <= 8'h00;
			end else if (FRAME_OK_O) begin
				frm_cnt_reg <= frm_cnt_reg + 8'h01;
			end
		end
	end

	// read data stands one cycle after the strobe, zero otherwise and for unmapped offsets
	always @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			RD_DATA_O <= 32'h00000000;
		end else if (CE_I) begin
			RD_DATA_O <= 32'h00000000;
			if (RD_STB_I) begin
				if (ADDR_I == `LDSR_REG_CTRL) begin
					RD_DATA_O <= {30'h00000000, ctrl_reg};
				end else if (ADDR_I == `LDSR_REG_STATUS) begin
					RD_DATA_O <= {27'h0000000, fifo_empty, ovf_reg, REVERSE_O, SCAN_EN_O,
						LOCAL_DIM_EN_O};
				end else if (ADDR_I == `LDSR_REG_ERRCNT) begin
					RD_DATA_O <= {24'h000000, err_cnt_reg};
				end else if (ADDR_I == `LDSR_REG_FRMCNT) begin
					RD_DATA_O <= {24'h000000, frm_cnt_reg};
				end else if (ADDR_I == `LDSR_REG_GRAY0) begin
					RD_DATA_O <= {{(32-GRAY_W){1'b0}}, gray_reg[0]};
				end else if (ADDR_I == `LDSR_REG_GRAY1) begin
					RD_DATA_O <= {{(32-GRAY_W){1'b0}}, gray_reg[1]};
				end else if (ADDR_I == `LDSR_REG_GRAY2) begin
					RD_DATA_O <= {{(32-GRAY_W){1'b0}}, gray_reg[2]};
				end else if (ADDR_I == `LDSR_REG_GRAY3) begin
					RD_DATA_O <= {{(32-GRAY_W){1'b0}}, gray_reg[3]};
				end
			end
		end
	end

endmodule

`default_nettype wire

//--- testbench/ldsr_chk_assertions.sv
// assertion checker for the local dimming serial receiver
`timescale 1ns/10ps
`default_nettype none
module ldsr_chk #(parameter GRAY_W = 10) (
	input wire logic SYS_CLK_I,
	input wire logic RESET_I,
	input wire logic CE_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [31:0] WR_DATA_I,
	input wire logic WR_STB_I,
	input wire logic RD_STB_I,
	input wire logic [31:0] RD_DATA_O,
	input wire logic LOCAL_DIM_EN_O,
	input wire logic SCAN_EN_O,
	input wire logic REVERSE_O,
	input wire logic [GRAY_W-1:0] GRAY0_O,
	input wire logic FRAME_OK_O,
	input wire logic CHECKSUM_ERR_O
);
	logic [1:0] ctrl_reg;
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (RESET_I);
	// shadow of the control bits so read-back has a reference
	always @(posedge SYS_CLK_I) begin
		if (RESET_I)
			ctrl_reg <= 2'h0;
		else if (CE_I && WR_STB_I && ADDR_I == 8'h00)
			ctrl_reg <= WR_DATA_I[1:0];
	end
	a_rd_idle: assert property ($past(CE_I) && !$past(RD_STB_I) |-> RD_DATA_O == 32'h0)
		else $error("read data not zero outside a read");
	a_rd_unmapped: assert property ($past(CE_I && RD_STB_I && ADDR_I > 8'h1C) |->
		RD_DATA_O == 32'h0) else $error("unmapped read not zero");
	a_ctrl_back: assert property ($past(CE_I && RD_STB_I && ADDR_I == 8'h00) |->
		RD_DATA_O == {30'h0, $past(ctrl_reg)}) else $error("control read-back wrong");
	a_status_mirror: assert property ($past(CE_I && RD_STB_I && ADDR_I == 8'h04) |->
		RD_DATA_O[2:0] == $past({REVERSE_O, SCAN_EN_O, LOCAL_DIM_EN_O}))
		else $error("status does not mirror command outputs");
	a_gray_read: assert property ($past(CE_I && RD_STB_I && ADDR_I == 8'h10) |->
		RD_DATA_O[GRAY_W-1:0] == $past(GRAY0_O)) else $error("gray read differs");
	a_ok_pulse: assert property (FRAME_OK_O |=> !FRAME_OK_O)
		else $error("frame ok longer than one cycle");
	a_err_pulse: assert property (CHECKSUM_ERR_O |=> !CHECKSUM_ERR_O)
		else $error("checksum error longer than one cycle");
	a_ok_err_excl: assert property (!(FRAME_OK_O && CHECKSUM_ERR_O))
		else $error("frame both good and bad");
	a_cmd_hold: assert property ($changed({REVERSE_O, SCAN_EN_O, LOCAL_DIM_EN_O}) &&
		!$past(RESET_I) |-> FRAME_OK_O) else $error("command outputs moved without good frame");
	a_gray_hold: assert property ($changed(GRAY0_O) && !$past(RESET_I) |-> FRAME_OK_O)
		else $error("gray moved without good frame");
	cover property (FRAME_OK_O && REVERSE_O);
	cover property (CHECKSUM_ERR_O);
	cover property ($past(RD_STB_I) && RD_DATA_O != 32'h0);
endmodule
bind ldsr_top ldsr_chk #(.GRAY_W(GRAY_W)) chk_u (.SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I),
	.CE_I(CE_I), .ADDR_I(ADDR_I), .WR_DATA_I(WR_DATA_I), .WR_STB_I(WR_STB_I),
	.RD_STB_I(RD_STB_I), .RD_DATA_O(RD_DATA_O), .LOCAL_DIM_EN_O(LOCAL_DIM_EN_O),
	.SCAN_EN_O(SCAN_EN_O), .REVERSE_O(REVERSE_O), .GRAY0_O(GRAY0_O),
	.FRAME_OK_O(FRAME_OK_O), .CHECKSUM_ERR_O(CHECKSUM_ERR_O));
`default_nettype wire

//--- testbench/ldsr_sender.sv
// link sender model: frame-sync, serial clock and data toward the receiver
`timescale 1ns/10ps
`default_nettype none
module ldsr_sender (
	output logic sync_o,
	output logic sclk_o,
	output logic sdo_o
);
	// serial clock idles low between frames
	initial begin
		sync_o = 1'b0;
		sclk_o = 1'b0;
		sdo_o = 1'b0;
	end
	// one frame; kind 1 spoils the checksum, kind 2 the indicator
	task automatic send(input logic f10, input logic [9:0] c, a, b, d, e, input int kind);
		logic [9:0] w [7];
		int nb;
		nb = f10 ? 10 : 8;
		w[0] = f10 ? 10'h280 : 10'h0AA;
		if (kind == 2)
			w[0] = w[0] ^ 10'h001;
		w[1] = c & ~10'h07C; // reserved bits 2 to 6 low
		w[2] = a;
		w[3] = b;
		w[4] = d;
		w[5] = e;
		w[6] = w[0] ^ w[1] ^ a ^ b ^ d ^ e ^ (kind == 1);
		// sync pulses whatever the command says, dimming on or off
		#3 sync_o = 1'b1; // one sequence per sync period
		#200 sync_o = 1'b0;
		#200;
		// msb first, data moves while the clock is low
		for (int i = 0; i < 7; i++) begin
			for (int k = nb - 1; k >= 0; k--) begin
				sdo_o = w[i][k];
				// period cut for run time; a real sender keeps its rate window
				#40 sclk_o = 1'b1;
				#40 sclk_o = 1'b0;
			end
		end
		sdo_o = ~sdo_o; // released line must not echo the last bit
	endtask
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// self-checking bench for the local dimming serial receiver
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic ce = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdat = 32'h0;
	wire sync, sclk, sdi, dim, scan, rev, ok, err;
	wire [31:0] rdat;
	wire [9:0] g0, g1, g2, g3;
	int bad_count = 0;
	int n_tests = 0;
	int ok_n = 0;
	int err_n = 0;
	always #5 clk = ~clk;
	ldsr_sender snd_u (.sync_o(sync), .sclk_o(sclk), .sdo_o(sdi));
	ldsr_top dut_u (.SYS_CLK_I(clk), .RESET_I(rst), .CE_I(ce), .FRAME_SYNC_PULSE_I(sync),
		.DIMMING_SERIAL_CLK_I(sclk), .DIMMING_SERIAL_INPUT_I(sdi), .ADDR_I(addr),
		.WR_DATA_I(wdat), .WR_STB_I(wr), .RD_STB_I(rd), .RD_DATA_O(rdat),
		.LOCAL_DIM_EN_O(dim), .SCAN_EN_O(scan), .REVERSE_O(rev), .GRAY0_O(g0),
		.GRAY1_O(g1), .GRAY2_O(g2), .GRAY3_O(g3), .FRAME_OK_O(ok), .CHECKSUM_ERR_O(err));
	// pulses are one cycle, so count them as they pass
	always @(posedge clk) begin
		if (ok === 1'b1)
			ok_n <= ok_n + 1;
		if (err === 1'b1)
			err_n <= err_n + 1;
	end
	task chk(input string n, input logic [39:0] e, s);
		n_tests++;
		if (s !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdat <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rd_reg(input logic [7:0] a, input logic [31:0] e, input string n);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(n, e, rdat);
	endtask
	task outs(input logic [2:0] c, input logic [39:0] g);
		chk("command outputs", {37'h0, c}, {37'h0, rev, scan, dim});
		chk("gray outputs", g, {g0, g1, g2, g3});
	endtask
	task automatic frame(input logic f10, input logic [9:0] c, a, b, d, e, input int kind, eo, ee);
		int o0, e0, i;
		o0 = ok_n;
		e0 = err_n;
		i = 0;
		snd_u.send(f10, c, a, b, d, e, kind);
		while (ok_n == o0 && err_n == e0 && i < 40) begin
			@(posedge clk);
			i++;
		end
		@(posedge clk);
		chk("good frames", o0 + eo, ok_n);
		chk("checksum errors", e0 + ee, err_n);
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// hang guard, about seven times the expected run
	initial begin
		#300000;
		bad_count++;
		final_report;
	end
	initial begin
		int j;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rd_reg(8'h00, 32'h0, "ctrl");
		rd_reg(8'h04, 32'h10, "status");
		rd_reg(8'h24, 32'h0, "unmapped");
		frame(1'b0, 10'h083, 10'h011, 10'h022, 10'h033, 10'h044, 0, 1, 0);
		outs(3'h7, {10'h011, 10'h022, 10'h033, 10'h044});
		rd_reg(8'h10, 32'h11, "gray0");
		rd_reg(8'h14, 32'h22, "gray1");
		rd_reg(8'h18, 32'h33, "gray2");
		rd_reg(8'h1C, 32'h44, "gray3");
		rd_reg(8'h04, 32'h17, "status");
		frame(1'b0, 10'h0FE, 10'h0AB, 10'h0CD, 10'h0EF, 10'h012, 1, 0, 1);
		outs(3'h7, {10'h011, 10'h022, 10'h033, 10'h044});
		rd_reg(8'h08, 32'h1, "error count");
		frame(1'b0, 10'h000, 10'h001, 10'h002, 10'h003, 10'h004, 2, 0, 0);
		outs(3'h7, {10'h011, 10'h022, 10'h033, 10'h044});
		wr_reg(8'h00, 32'h1);
		rd_reg(8'h00, 32'h1, "ctrl");
		frame(1'b1, 10'h002, 10'h3FF, 10'h200, 10'h155, 10'h000, 0, 1, 0);
		outs(3'h2, {10'h3FF, 10'h200, 10'h155, 10'h000});
		wr_reg(8'h08, 32'h0);
		rd_reg(8'h08, 32'h0, "error count");
		// hold the fifo and overfill it with three frames
		wr_reg(8'h00, 32'h2);
		repeat (3) frame(1'b0, 10'h001, 10'h005, 10'h006, 10'h007, 10'h008, 0, 0, 0);
		rd_reg(8'h04, 32'h0A, "status");
		j = ok_n + 2;
		wr_reg(8'h00, 32'h0);
		for (int i = 0; i < 100 && ok_n != j; i++)
			@(posedge clk);
		chk("drained frames", j, ok_n);
		outs(3'h1, {10'h005, 10'h006, 10'h007, 10'h008});
		wr_reg(8'h04, 32'h8);
		rd_reg(8'h04, 32'h11, "status");
		frame(1'b0, 10'h080, 10'h0FF, 10'h000, 10'h081, 10'h07E, 0, 1, 0);
		outs(3'h4, {10'h0FF, 10'h000, 10'h081, 10'h07E});
		rd_reg(8'h0C, 32'h5, "frame count");
		// a write while the clock enable is low must not land
		@(posedge clk);
		ce <= 1'b0;
		wr_reg(8'h00, 32'h1);
		ce <= 1'b1;
		rd_reg(8'h00, 32'h0, "ctrl after frozen write");
		// a reset in mid-run clears outputs and counters
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		outs(3'h0, 40'h0);
		rd_reg(8'h0C, 32'h0, "frame count after reset");
		rd_reg(8'h04, 32'h10, "status after reset");
		final_report;
	end
endmodule
`default_nettype wire
